/* src/dcb_pkg.sv */
package dcb_pkg;
  // bus register byte offsets
  localparam logic [7:0]  DCB_OFS_START_FREQ   = 8'h00;
  localparam logic [7:0]  DCB_OFS_DURATION     = 8'h04;
  localparam logic [7:0]  DCB_OFS_VOLTAGE      = 8'h08;
  localparam logic [7:0]  DCB_OFS_REGEN_SEL    = 8'h0C;
  localparam logic [7:0]  DCB_OFS_SPECIAL_DUTY = 8'h10;
  localparam logic [7:0]  DCB_OFS_MOTOR_CODE   = 8'h14;
  localparam logic [7:0]  DCB_OFS_STATUS       = 8'h18;
  localparam logic [7:0]  DCB_OFS_TERM_BASE    = 8'h20;
  // ranges and reset values; frequency in 0.01 Hz, duration in 0.1 s, percent in 1 %
  localparam logic [15:0] DCB_FREQ_MAX         = 16'h2EE0;
  localparam logic [15:0] DCB_FREQ_RESET       = 16'h012C;
  localparam logic [15:0] DCB_DUR_MAX          = 16'h0064;
  localparam logic [15:0] DCB_DUR_RESET        = 16'h0005;
  localparam logic [15:0] DCB_VOLT_MAX         = 16'h001E;
  localparam logic [15:0] DCB_VOLT_SMALL       = 16'h0006;
  localparam logic [15:0] DCB_VOLT_MIDDLE      = 16'h0004;
  localparam logic [15:0] DCB_VOLT_LARGE       = 16'h0002;
  localparam logic [15:0] DCB_REGEN_SEL_MAX    = 16'h0002;
  localparam logic [15:0] DCB_REGEN_SEL_RESET  = 16'h0000;
  localparam logic [15:0] DCB_DUTY_MAX         = 16'h001E;
  localparam logic [15:0] DCB_DUTY_RESET       = 16'h0000;
  localparam logic [15:0] DCB_MOTOR_RESET      = 16'h0000;
  localparam logic [7:0]  DCB_TERM_RESET       = 8'hFF;
  localparam logic [7:0]  DCB_FUNC_OP_ENABLE   = 8'h0A;
  localparam int          DCB_TERM_FUNC_W      = 8;
  localparam int          DCB_NUM_TERMS        = 7;
  // status word fields
  localparam int          DCB_ST_BRAKE         = 0;
  localparam int          DCB_ST_OUT_EN        = 1;
  localparam int          DCB_ST_COAST         = 2;
  localparam int          DCB_ST_EN_ASSIGNED   = 3;
  localparam int          DCB_ST_LEVEL_LSB     = 8;
  localparam int          DCB_ST_DUTY_LSB      = 16;
  // timing
  localparam int          DCB_CLK_PERIOD_NS    = 10;
  localparam int          DCB_DUR_UNIT_MS      = 100;
  localparam int          DCB_DUR_UNIT_CYCLES  = DCB_DUR_UNIT_MS * 1000000 / DCB_CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    DCB_IDLE  = 3'b001,
    DCB_BRAKE = 3'b010,
    DCB_COAST = 3'b100
  } dcb_state_e;

  function automatic logic dcb_is_std_motor(input logic [15:0] code);
    return code inside {16'd0, 16'd3, 16'd4, 16'd5, 16'd6, 16'd23, 16'd24, 16'd40, 16'd43, 16'd44};
  endfunction : dcb_is_std_motor

  function automatic logic dcb_is_ct_motor(input logic [15:0] code);
    return code inside {16'd1, 16'd13, 16'd14, 16'd15, 16'd16, 16'd50, 16'd53, 16'd54};
  endfunction : dcb_is_ct_motor

  function automatic logic [15:0] dcb_merge(input logic [15:0] old_v, input logic [31:0] wd,
                                            input logic [3:0] be);
    return {be[1] ? wd[15:8] : old_v[15:8], be[0] ? wd[7:0] : old_v[7:0]};
  endfunction : dcb_merge
endpackage : dcb_pkg

/* src/dcb_timer.sv */
`timescale 1ns/1ps
module dcb_timer
  import dcb_pkg::*;
#(
  parameter int TICK_CYCLES = DCB_DUR_UNIT_CYCLES
) (
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        start_i,
  input  wire logic        abort_i,
  input  wire logic [15:0] units_i,
  output logic             busy_o,
  output logic             done_o
);
  localparam int PW = $clog2(TICK_CYCLES + 1);
  localparam logic [PW-1:0] PRE_LAST = PW'(TICK_CYCLES - 1);

  logic [PW-1:0] pre_r;
  logic [15:0]   units_r;

  // (R2) count whole units
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pre_r   <= '0;
      units_r <= 16'h0000;
      busy_o  <= 1'b0;
      done_o  <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        pre_r   <= '0;
        units_r <= units_i;
        busy_o  <= 1'b1;
      end else if (abort_i) begin
        busy_o <= 1'b0;
      end else if (busy_o) begin
        if (pre_r == PRE_LAST) begin
          pre_r   <= '0;
          units_r <= units_r - 16'h0001;
          if (units_r == 16'h0001) begin
            busy_o <= 1'b0;
            done_o <= 1'b1;
          end
        end else begin
          pre_r <= pre_r + PW'(1);
        end
      end
    end
  end
endmodule : dcb_timer

/* src/dcb_term_route.sv */
`timescale 1ns/1ps
module dcb_term_route
  import dcb_pkg::*;
#(
  parameter int N = DCB_NUM_TERMS,
  parameter int W = DCB_TERM_FUNC_W
) (
  input  wire logic [N*W-1:0] func_codes_i,
  input  wire logic [N-1:0]   contact_i,
  input  wire logic [W-1:0]   match_code_i,
  output logic                assigned_o,
  output logic                level_o
);
  logic [N-1:0] hit;

  // (R14) match function code per terminal
  for (genvar i = 0; i < N; i++) begin : g_term
    assign hit[i] = (func_codes_i[i*W +: W] == match_code_i);
  end

  // an unassigned enable counts as permanently asserted
  assign assigned_o = |hit;
  assign level_o    = assigned_o ? |(hit & contact_i) : 1'b1;
endmodule : dcb_term_route

/* src/dcb_brake_ctrl.sv */
// Local design decisions: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
// Behaviour
// (R1) brake starts at threshold during deceleration
// (R2) brake held for programmed duration
// (R3) zero duration means coast, no brake
// (R4) voltage setting is percent, 0-30
// (R5) zero voltage means coast, no brake
// (R6) voltage resets by power rating class
// (R7) 4% becomes 2% on constant-torque motor
// (R8) 2% becomes 4% on standard motor
// (R9) brake current kept within rated current
// (R10) regen select defaults 0, allows 2
// (R11) special regen duty 0-30%, default 0
// (R12) select 0 uses fixed series duty
// (R13) output shut off without operation enable
// (R14) enable comes from terminal coded 10
// (R15) duration times from threshold, then shutoff
module dcb_brake_ctrl
  import dcb_pkg::*;
#(
  parameter int          RATING_CLASS = 1,
  parameter bit          AUTO_VOLT    = 1'b1,
  parameter logic [15:0] FIXED_DUTY   = 16'h0003,
  parameter logic [15:0] RATED_CURR   = 16'h03E8,
  parameter int          TICK_CYCLES  = DCB_DUR_UNIT_CYCLES
) (
  input  wire logic                     core_clk_i,
  input  wire logic                     rst_i,
  input  wire logic [7:0]               avs_address_i,
  input  wire logic                     avs_read_i,
  input  wire logic                     avs_write_i,
  input  wire logic [31:0]              avs_writedata_i,
  input  wire logic [3:0]               avs_byteenable_i,
  output logic      [31:0]              avs_readdata_o,
  output logic                          avs_waitrequest_o,
  input  wire logic                     decel_i,
  input  wire logic [15:0]              out_freq_i,
  input  wire logic [15:0]              out_current_i,
  input  wire logic [DCB_NUM_TERMS-1:0] contact_in_i,
  output logic                          dc_brake_o,
  output logic      [15:0]              dc_brake_level_o,
  output logic                          output_enable_o,
  output logic      [15:0]              regen_duty_o
);
  localparam logic [15:0] VOLT_RESET = (RATING_CLASS == 0) ? DCB_VOLT_SMALL :
                                       (RATING_CLASS == 2) ? DCB_VOLT_LARGE : DCB_VOLT_MIDDLE;
  localparam int TW = DCB_TERM_FUNC_W;

  logic [15:0]                 brake_start_frequency_r;
  logic [15:0]                 brake_duration_r;
  logic [15:0]                 brake_voltage_percent_r;
  logic [15:0]                 regen_function_select_r;
  logic [15:0]                 special_regen_duty_r;
  logic [15:0]                 applied_motor_code_r;
  logic [DCB_NUM_TERMS*TW-1:0] input_terminal_function_select_r;
  dcb_state_e                  state_r;
  dcb_state_e                  state_nxt;
  logic                        en_assigned;
  logic                        en_level;
  logic                        enable_r;
  logic                        assigned_r;
  logic                        tmr_busy;
  logic                        tmr_done;
  logic                        trigger;
  logic                        brake_ok;
  logic                        req;
  logic                        wr_go;
  logic [15:0]                 wd16;
  logic [15:0]                 level_nxt;
  logic [31:0]                 rd_nxt;
  logic [31:0]                 status_w;

  // ---------------- bus slave: one wait state per access ----------------
  assign req   = avs_read_i | avs_write_i;
  assign wr_go = avs_write_i & ~avs_waitrequest_o;
  assign wd16  = avs_writedata_i[15:0];

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= ~(req & avs_waitrequest_o);
    end
  end

  assign status_w = {8'h00, regen_duty_o[7:0], dc_brake_level_o[7:0], 4'h0, assigned_r,
                     state_r == DCB_COAST, output_enable_o, dc_brake_o};

  always_comb begin
    rd_nxt = 32'h0000_0000;
    unique case (avs_address_i)
      DCB_OFS_START_FREQ:   rd_nxt = {16'h0000, brake_start_frequency_r};
      DCB_OFS_DURATION:     rd_nxt = {16'h0000, brake_duration_r};
      DCB_OFS_VOLTAGE:      rd_nxt = {16'h0000, brake_voltage_percent_r};
      DCB_OFS_REGEN_SEL:    rd_nxt = {16'h0000, regen_function_select_r};
      DCB_OFS_SPECIAL_DUTY: rd_nxt = {16'h0000, special_regen_duty_r};
      DCB_OFS_MOTOR_CODE:   rd_nxt = {16'h0000, applied_motor_code_r};
      DCB_OFS_STATUS:       rd_nxt = status_w;
      default: begin
        for (int i = 0; i < DCB_NUM_TERMS; i++) begin
          if (avs_address_i == DCB_OFS_TERM_BASE + 8'(4 * i)) begin
            rd_nxt = {24'h000000, input_terminal_function_select_r[i*TW +: TW]};
          end
        end
      end
    endcase
  end

  // read data loaded one edge before the master samples it
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (avs_read_i & avs_waitrequest_o) begin
      avs_readdata_o <= rd_nxt;
    end
  end

  // ---------------- settings; out-of-range writes are dropped ----------------
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      brake_start_frequency_r <= DCB_FREQ_RESET;
      brake_duration_r        <= DCB_DUR_RESET;
      regen_function_select_r <= DCB_REGEN_SEL_RESET;
      special_regen_duty_r    <= DCB_DUTY_RESET;
      applied_motor_code_r    <= DCB_MOTOR_RESET;
    end else if (wr_go) begin
      // (R1) threshold range check
      if (avs_address_i == DCB_OFS_START_FREQ &&
          dcb_merge(brake_start_frequency_r, avs_writedata_i, avs_byteenable_i) <= DCB_FREQ_MAX) begin
        brake_start_frequency_r <= dcb_merge(brake_start_frequency_r, avs_writedata_i, avs_byteenable_i);
      end
      // (R2) duration range check
      if (avs_address_i == DCB_OFS_DURATION &&
          dcb_merge(brake_duration_r, avs_writedata_i, avs_byteenable_i) <= DCB_DUR_MAX) begin
        brake_duration_r <= dcb_merge(brake_duration_r, avs_writedata_i, avs_byteenable_i);
      end
      // (R10) selection 0, 1 or 2 only
      if (avs_address_i == DCB_OFS_REGEN_SEL &&
          dcb_merge(regen_function_select_r, avs_writedata_i, avs_byteenable_i) <= DCB_REGEN_SEL_MAX) begin
        regen_function_select_r <= dcb_merge(regen_function_select_r, avs_writedata_i, avs_byteenable_i);
      end
      // (R11) special duty range check
      if (avs_address_i == DCB_OFS_SPECIAL_DUTY &&
          dcb_merge(special_regen_duty_r, avs_writedata_i, avs_byteenable_i) <= DCB_DUTY_MAX) begin
        special_regen_duty_r <= dcb_merge(special_regen_duty_r, avs_writedata_i, avs_byteenable_i);
      end
      if (avs_address_i == DCB_OFS_MOTOR_CODE) begin
        applied_motor_code_r <= dcb_merge(applied_motor_code_r, avs_writedata_i, avs_byteenable_i);
      end
    end
  end

  // voltage kept apart: software writes it and a motor change rewrites it
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      // (R6) reset by rating class
      brake_voltage_percent_r <= VOLT_RESET;
    end else if (wr_go) begin
      // (R4) percent up to 30
      if (avs_address_i == DCB_OFS_VOLTAGE &&
          dcb_merge(brake_voltage_percent_r, avs_writedata_i, avs_byteenable_i) <= DCB_VOLT_MAX) begin
        brake_voltage_percent_r <= dcb_merge(brake_voltage_percent_r, avs_writedata_i, avs_byteenable_i);
      end
      if (AUTO_VOLT && avs_address_i == DCB_OFS_MOTOR_CODE) begin
        // (R7) standard to constant-torque
        if (brake_voltage_percent_r == DCB_VOLT_MIDDLE && dcb_is_std_motor(applied_motor_code_r) &&
            dcb_is_ct_motor(dcb_merge(applied_motor_code_r, avs_writedata_i, avs_byteenable_i))) begin
          brake_voltage_percent_r <= DCB_VOLT_LARGE;
        end
        // (R8) constant-torque to standard
        if (brake_voltage_percent_r == DCB_VOLT_LARGE && dcb_is_ct_motor(applied_motor_code_r) &&
            dcb_is_std_motor(dcb_merge(applied_motor_code_r, avs_writedata_i, avs_byteenable_i))) begin
          brake_voltage_percent_r <= DCB_VOLT_MIDDLE;
        end
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      input_terminal_function_select_r <= {DCB_NUM_TERMS{DCB_TERM_RESET}};
    end else if (wr_go && avs_byteenable_i[0]) begin
      for (int i = 0; i < DCB_NUM_TERMS; i++) begin
        if (avs_address_i == DCB_OFS_TERM_BASE + 8'(4 * i)) begin
          input_terminal_function_select_r[i*TW +: TW] <= avs_writedata_i[TW-1:0];
        end
      end
    end
  end

  // ---------------- operation enable ----------------
  dcb_term_route #(
    .N (DCB_NUM_TERMS),
    .W (TW)
  ) u_route (
    .func_codes_i (input_terminal_function_select_r),
    .contact_i    (contact_in_i),
    .match_code_i (DCB_FUNC_OP_ENABLE),
    .assigned_o   (en_assigned),
    .level_o      (en_level)
  );

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      enable_r   <= 1'b0;
      assigned_r <= 1'b0;
    end else begin
      enable_r   <= en_level;
      assigned_r <= en_assigned;
    end
  end

  // ---------------- stop braking sequence ----------------
  assign trigger  = decel_i && (out_freq_i <= brake_start_frequency_r);
  // zero time or zero voltage disables the brake
  assign brake_ok = (brake_duration_r != 16'h0000) && (brake_voltage_percent_r != 16'h0000);

  dcb_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timer (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .start_i    (state_r == DCB_IDLE && state_nxt == DCB_BRAKE),
    .abort_i    (state_r == DCB_BRAKE && state_nxt != DCB_BRAKE),
    .units_i    (brake_duration_r),
    .busy_o     (tmr_busy),
    .done_o     (tmr_done)
  );

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      DCB_IDLE: begin
        // (R1) enter brake at threshold
        if (trigger && enable_r) begin
          // (R3) (R5) coast when disabled
          state_nxt = brake_ok ? DCB_BRAKE : DCB_COAST;
        end
      end
      DCB_BRAKE: begin
        // (R15) expiry or lost enable ends brake
        if (tmr_done || !enable_r) begin
          state_nxt = DCB_COAST;
        end
      end
      DCB_COAST: begin
        if (!decel_i) begin
          state_nxt = DCB_IDLE;
        end
      end
      default: state_nxt = DCB_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r         <= DCB_IDLE;
      dc_brake_o      <= 1'b0;
      output_enable_o <= 1'b0;
    end else begin
      state_r         <= state_nxt;
      dc_brake_o      <= (state_nxt == DCB_BRAKE);
      // (R13) no enable, no output
      output_enable_o <= en_level && enable_r && (state_nxt != DCB_COAST);
    end
  end

  // level ramps one percent per cycle; backs off while current is above rating
  always_comb begin
    level_nxt = 16'h0000;
    if (state_nxt == DCB_BRAKE) begin
      // (R9) back off above rated current
      if (out_current_i > RATED_CURR && dc_brake_level_o != 16'h0000) begin
        level_nxt = dc_brake_level_o - 16'h0001;
      end else if (out_current_i > RATED_CURR) begin
        level_nxt = 16'h0000;
      // (R4) approach programmed percent
      end else if (dc_brake_level_o < brake_voltage_percent_r) begin
        level_nxt = dc_brake_level_o + 16'h0001;
      end else begin
        level_nxt = brake_voltage_percent_r;
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      dc_brake_level_o <= 16'h0000;
      regen_duty_o     <= 16'h0000;
    end else begin
      dc_brake_level_o <= level_nxt;
      // (R12) fixed duty when selection is 0
      regen_duty_o     <= (regen_function_select_r == DCB_REGEN_SEL_RESET) ? FIXED_DUTY : special_regen_duty_r;
    end
  end

  // ---------------- assertions ----------------
  sequence s_trig_ok;
    state_r == DCB_IDLE && trigger && enable_r && brake_ok;
  endsequence

  a_brake_entry: assert property (@(posedge core_clk_i) disable iff (rst_i) // (R1)
    s_trig_ok |=> dc_brake_o && state_r == DCB_BRAKE)
    else $error("brake did not start at threshold");
  a_zero_duration: assert property (@(posedge core_clk_i) disable iff (rst_i) // (R3)
    state_r == DCB_IDLE && trigger && enable_r && brake_duration_r == 16'h0000 |=> !dc_brake_o && !output_enable_o)
    else $error("zero duration still braked");
  a_zero_voltage: assert property (@(posedge core_clk_i) disable iff (rst_i) // (R5)
    state_r == DCB_IDLE && trigger && enable_r && brake_voltage_percent_r == 16'h0000 |=> state_r == DCB_COAST)
    else $error("zero voltage still braked");
  a_level_bound: assert property (@(posedge core_clk_i) disable iff (rst_i) // (R4)
    dc_brake_o |-> dc_brake_level_o <= brake_voltage_percent_r && brake_voltage_percent_r <= DCB_VOLT_MAX)
    else $error("brake level above setting");
  a_current_limit: assert property (@(posedge core_clk_i) disable iff (rst_i) // (R9)
    dc_brake_o && out_current_i > RATED_CURR && dc_brake_level_o != 16'h0000 |=>
      dc_brake_level_o < $past(dc_brake_level_o))
    else $error("brake level not reduced on overcurrent");
  a_duration_end: assert property (@(posedge core_clk_i) disable iff (rst_i) // (R15)
    tmr_done && state_r == DCB_BRAKE |=> !dc_brake_o && !output_enable_o && dc_brake_level_o == 16'h0000)
    else $error("output not shut off at brake end");
  a_hold_brake: assert property (@(posedge core_clk_i) disable iff (rst_i) // (R2)
    $rose(dc_brake_o) |-> tmr_busy [*2])
    else $error("brake timer not running");
  a_motor_ct: assert property (@(posedge core_clk_i) disable iff (rst_i) // (R7)
    AUTO_VOLT && wr_go && avs_address_i == DCB_OFS_MOTOR_CODE && avs_byteenable_i == 4'hF &&
      brake_voltage_percent_r == DCB_VOLT_MIDDLE && dcb_is_std_motor(applied_motor_code_r) &&
      dcb_is_ct_motor(wd16) |=> brake_voltage_percent_r == DCB_VOLT_LARGE)
    else $error("voltage not moved to 2 percent");
  a_motor_std: assert property (@(posedge core_clk_i) disable iff (rst_i) // (R8)
    AUTO_VOLT && wr_go && avs_address_i == DCB_OFS_MOTOR_CODE && avs_byteenable_i == 4'hF &&
      brake_voltage_percent_r == DCB_VOLT_LARGE && dcb_is_ct_motor(applied_motor_code_r) &&
      dcb_is_std_motor(wd16) |=> brake_voltage_percent_r == DCB_VOLT_MIDDLE)
    else $error("voltage not moved to 4 percent");
  a_enable_off: assert property (@(posedge core_clk_i) disable iff (rst_i) // (R13)
    !en_level |=> !output_enable_o ##1 !output_enable_o)
    else $error("output on without operation enable");
  a_regen_fixed: assert property (@(posedge core_clk_i) disable iff (rst_i) // (R12)
    regen_function_select_r == 16'h0000 && $stable(regen_function_select_r) |=> regen_duty_o == FIXED_DUTY)
    else $error("fixed regen duty not used");
  a_bus_wait: assert property (@(posedge core_clk_i) disable iff (rst_i)
    req && avs_waitrequest_o |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("bus answer not one wait state");
endmodule : dcb_brake_ctrl

/* verif/dcb_motor_model.sv */
`timescale 1ns/1ps
module dcb_motor_model (
  input  wire logic        core_clk_i,
  input  wire logic        stop_i,
  input  wire logic        ready_i,
  input  wire logic        overload_i,
  input  wire logic        output_enable_i,
  output logic             decel_o = 1'b0,
  output logic      [15:0] freq_o = 16'h03E8,
  output logic      [15:0] current_o,
  output logic             ready_o
);
  // frequency falls 1 Hz a cycle while stopping and is re-armed at 10 Hz otherwise
  always @(posedge core_clk_i) begin
    decel_o <= stop_i;
    if (!stop_i)
      freq_o <= 16'h03E8;
    else if (freq_o >= 16'h0064)
      freq_o <= freq_o - 16'h0064;
  end
  // a stalled load draws twice the rated current, so the limit must act
  assign current_o = overload_i ? 16'h07D0 : (output_enable_i ? 16'h0190 : 16'h0000);
  assign ready_o = ready_i;
endmodule : dcb_motor_model

/* verif/test_dc_brake_and_regen_select.sv */
`timescale 1ns/1ps
module test_dc_brake_and_regen_select;
  import dcb_pkg::*;
  logic        core_clk_i  = 1'b0;
  logic        rst_i       = 1'b1;
  logic [7:0]  adr         = 8'h00;
  logic        rd          = 1'b0;
  logic        wr          = 1'b0;
  logic [15:0] wdat        = 16'h0000;
  logic        stop        = 1'b0;
  logic        ready       = 1'b1;
  logic        ovl         = 1'b0;
  logic [5:0]  spare       = 6'h00;
  logic [31:0] rdat;
  logic        wait_req, decel, brake, oen, rdy;
  logic [15:0] freq, curr, level, duty, dm, top, start_f, lst;
  logic [63:0] exp_q[$];
  logic [63:0] e;
  int          errors      = 0;
  int          check_count = 0;
  int          cyc         = 0;
  int          on_cyc      = 0;
  int          seed        = 32'h577e;
  int          n;

  always #5 core_clk_i = ~core_clk_i;

  dcb_brake_ctrl #(.TICK_CYCLES(4)) u_dut (
    .core_clk_i        (core_clk_i),
    .rst_i             (rst_i),
    .avs_address_i     (adr),
    .avs_read_i        (rd),
    .avs_write_i       (wr),
    .avs_writedata_i   ({16'h0000, wdat}),
    .avs_byteenable_i  (4'hF),
    .avs_readdata_o    (rdat),
    .avs_waitrequest_o (wait_req),
    .decel_i           (decel),
    .out_freq_i        (freq),
    .out_current_i     (curr),
    .contact_in_i      ({spare[5:3], rdy, spare[2:0]}),
    .dc_brake_o        (brake),
    .dc_brake_level_o  (level),
    .output_enable_o   (oen),
    .regen_duty_o      (duty)
  );

  dcb_motor_model u_motor (
    .core_clk_i      (core_clk_i),
    .stop_i          (stop),
    .ready_i         (ready),
    .overload_i      (ovl),
    .output_enable_i (oen),
    .decel_o         (decel),
    .freq_o          (freq),
    .current_o       (curr),
    .ready_o         (rdy)
  );

  task automatic chk(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      errors++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask : chk

  task automatic results;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results

  // reads leave their expectation in the queue; the watcher compares when waitrequest drops
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d,
                     input logic [31:0] x = 0, input logic [31:0] m = 32'hFFFF_FFFF);
    if (!w) exp_q.push_back({x, m});
    adr <= a;
    wdat <= d;
    wr <= w;
    rd <= !w;
    do @(posedge core_clk_i); while (wait_req !== 1'b0);
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge core_clk_i);
  endtask : bus

  always @(posedge core_clk_i) begin
    cyc++;
    spare <= 6'($random(seed));
    if (brake === 1'b1) begin
      on_cyc++;
      if (on_cyc == 1) start_f = freq;
      if (level > top) top = level;
      lst = level;
    end
    if (rd && wait_req === 1'b0) begin
      e = exp_q.pop_front();
      chk((rdat & e[31:0]) === (e[63:32] & e[31:0]), "read data");
    end
    if (cyc == 4000) begin
      errors++;
      results();
    end
  end

  task automatic run(input logic [15:0] dur, input logic [15:0] volt, input logic o);
    bus(1, DCB_OFS_DURATION, dur);
    bus(1, DCB_OFS_VOLTAGE, volt);
    on_cyc = 0;
    top = 16'h0000;
    stop <= 1'b1;
    // overload lands while the level is still ramping, so the limiter has to pull it back
    repeat (12) @(posedge core_clk_i);
    ovl <= o;
    repeat (18) @(posedge core_clk_i);
    n = (dur == 0 || volt == 0) ? 0 : 4 * dur;
    chk(on_cyc >= n && on_cyc <= n + (n > 0 ? 2 : 0), "brake length");
    if (n > 0) chk(start_f === DCB_FREQ_RESET - 16'h0064, "brake start");
    if (n > 0) chk(o ? (top < volt && lst === 16'h0000) : top === volt, "brake level");
    bus(0, DCB_OFS_STATUS, 0, 32'h0000_0004, 32'h0000_FF07);
    stop <= 1'b0;
    ovl <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    bus(0, DCB_OFS_STATUS, 0, 32'h0000_0002, 32'h0000_0007);
    $display("test stop run done");
  endtask : run

  initial begin
    repeat (5) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(posedge core_clk_i);
    bus(0, DCB_OFS_START_FREQ, 0, DCB_FREQ_RESET);
    bus(0, DCB_OFS_DURATION, 0, DCB_DUR_RESET);
    bus(0, DCB_OFS_VOLTAGE, 0, DCB_VOLT_MIDDLE);
    bus(0, DCB_OFS_REGEN_SEL, 0, DCB_REGEN_SEL_RESET);
    bus(0, DCB_OFS_SPECIAL_DUTY, 0, DCB_DUTY_RESET);
    bus(0, DCB_OFS_TERM_BASE, 0, DCB_TERM_RESET);
    bus(0, 8'h1C, 0, 32'h0000_0000);
    bus(0, DCB_OFS_STATUS, 0, 32'h0003_0002, 32'h00FF_000B);
    $display("test reset values done");
    dm = DCB_DUTY_RESET;
    bus(1, DCB_OFS_REGEN_SEL, 16'h0002);
    bus(1, DCB_OFS_REGEN_SEL, 16'h0003);
    bus(0, DCB_OFS_REGEN_SEL, 0, 32'h0000_0002);
    repeat (4) begin
      n = $unsigned($random(seed)) % 40;
      bus(1, DCB_OFS_SPECIAL_DUTY, 16'(n));
      if (n <= 30) dm = 16'(n);
      bus(0, DCB_OFS_STATUS, 0, {8'h00, dm[7:0], 16'h0000}, 32'h00FF_0000);
      chk(duty === dm, "special duty");
    end
    bus(1, DCB_OFS_REGEN_SEL, 16'h0000);
    bus(0, DCB_OFS_STATUS, 0, 32'h0003_0000, 32'h00FF_0000);
    chk(duty === 16'h0003, "fixed duty");
    $display("test regen duty done");
    bus(1, DCB_OFS_MOTOR_CODE, 16'h000E);
    bus(0, DCB_OFS_VOLTAGE, 0, 32'h0000_0002);
    bus(1, DCB_OFS_MOTOR_CODE, 16'h002C);
    bus(0, DCB_OFS_VOLTAGE, 0, 32'h0000_0004);
    $display("test motor code done");
    run(16'h0002, 16'h0003, 1'b0);
    run(16'h0000, 16'h0004, 1'b0);
    run(16'h0001, 16'h0000, 1'b0);
    run(16'h0003, 16'h0006, 1'b1);
    bus(1, DCB_OFS_TERM_BASE + 8'h0C, {8'h00, DCB_FUNC_OP_ENABLE});
    ready <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    bus(0, DCB_OFS_STATUS, 0, 32'h0000_0008, 32'h0000_000A);
    chk(oen === 1'b0, "output on without enable");
    ready <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    bus(0, DCB_OFS_STATUS, 0, 32'h0000_000A, 32'h0000_000A);
    chk(oen === 1'b1, "output not restored");
    $display("test operation enable done");
    results();
  end
endmodule : test_dc_brake_and_regen_select
